// >>> src/rpu_pkg.sv
package rpu_pkg;

  localparam int          RPU_REGIONS     = 8;
  localparam int          RPU_SUBREGIONS  = 8;
  localparam logic [31:0] RPU_SYS_BASE    = 32'h2000_0000;
  localparam logic [7:0]  RPU_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  RPU_OFF_FADDR   = 8'h04;
  localparam logic [7:0]  RPU_OFF_FINFO   = 8'h08;
  localparam logic [7:0]  RPU_OFF_RGN0    = 8'h10;
  localparam int          RPU_RGN_STRIDE  = 8;
  localparam int          RPU_MIN_SIZE    = 4;
  localparam int          RPU_MIN_SRD     = 7;
  localparam logic [31:0] RPU_RST_WORD    = 32'h0000_0000;
  localparam int          RPU_ATTR_EN     = 0;
  localparam int          RPU_ATTR_SIZE   = 1;
  localparam int          RPU_ATTR_SRD    = 8;
  localparam int          RPU_ATTR_PERM   = 16;

  typedef enum logic [1:0] {
    RPU_PERM_NONE = 2'h0,
    RPU_PERM_RO   = 2'h1,
    RPU_PERM_RW   = 2'h2,
    RPU_PERM_RES  = 2'h3
  } rpu_perm_t;

  typedef struct packed {
    logic [26:0] base;
    logic        en;
    logic [4:0]  size;
    logic [7:0]  srd;
    rpu_perm_t   perm;
  } rpu_region_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic [31:0] addr;
  } rpu_acc_t;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } rpu_ppb_t;

endpackage

// >>> src/rpu_top.sv
`timescale 1ns/1ps
// Functional notes
// - Eight regions, each with eight subregions when its size field is 7 or more.
// - Unmatched or disallowed access faults and blocks.
// - Read-only region allows reads, rejects writes.
// - No-access region rejects every access.
// - Code region addresses go to code port.
// - Addresses from 0x20000000 go to system port.
// - Region settings programmed only over private bus.
module rpu_top
  import rpu_pkg::*;
#(
  parameter int NREG = RPU_REGIONS
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Core access request
  input  wire rpu_acc_t    acc_in,
  // Private peripheral bus
  input  wire rpu_ppb_t    ppb_in,
  output logic [31:0]      ppb_rdata,
  // Routed accesses
  output rpu_acc_t         code_out,
  output rpu_acc_t         sys_out,
  // Fault event
  output logic             mm_fault,
  output logic [31:0]      mm_fault_addr
);

  rpu_region_t       rgn_r [NREG];
  rpu_region_t       rgn_nxt [NREG];
  logic              unit_en_r;
  logic              unit_en_nxt;
  logic [31:0]       ppb_rdata_r;
  logic [31:0]       ppb_rdata_nxt;
  rpu_acc_t          code_r;
  rpu_acc_t          code_nxt;
  rpu_acc_t          sys_r;
  rpu_acc_t          sys_nxt;
  logic              fault_r;
  logic              fault_nxt;
  logic [31:0]       faddr_r;
  logic [31:0]       faddr_nxt;
  logic [2:0]        finfo_r;
  logic [2:0]        finfo_nxt;

  logic              hit;
  rpu_perm_t         hit_perm;
  logic              allowed;

  // Region lookup: later regions override earlier ones
  always_comb
  begin
    logic [5:0]  sh;
    logic [31:0] mask;
    logic [2:0]  sub;
    logic [31:0] rbase;
    hit      = 1'b0;
    hit_perm = RPU_PERM_NONE;
    sh       = 6'h00;
    mask     = 32'h0000_0000;
    sub      = 3'h0;
    rbase    = 32'h0000_0000;
    for (int i = 0; i < NREG; i++)
    begin
      sh    = 6'(rgn_r[i].size) + 6'h01;
      mask  = (sh >= 6'd32) ? 32'h0000_0000 : (32'hffff_ffff << sh);
      rbase = {rgn_r[i].base, 5'h00};
      sub   = 3'((acc_in.addr >> (sh - 6'h03)) & 32'h0000_0007);
      if (rgn_r[i].en && (int'(rgn_r[i].size) >= RPU_MIN_SIZE) &&
          ((acc_in.addr & mask) == (rbase & mask)) &&
          !((int'(rgn_r[i].size) >= RPU_MIN_SRD) && rgn_r[i].srd[sub]))
      begin
        hit      = 1'b1;
        hit_perm = rgn_r[i].perm;
      end
    end
    // The reserved permission code is treated as no access
    case (hit_perm)
      RPU_PERM_RW:   allowed = hit;
      RPU_PERM_RO:   allowed = hit && !acc_in.write;
      RPU_PERM_NONE: allowed = 1'b0;
      default:       allowed = 1'b0;
    endcase
    // Unit off: every access passes and is routed by address only
    if (!unit_en_r)
    begin
      allowed = 1'b1;
    end
  end

  // Access routing and fault generation
  always_comb
  begin
    code_nxt       = '0;
    sys_nxt        = '0;
    fault_nxt      = 1'b0;
    faddr_nxt      = faddr_r;
    finfo_nxt      = finfo_r;
    if (acc_in.valid)
    begin
      if (!allowed)
      begin
        fault_nxt = 1'b1;
        faddr_nxt = acc_in.addr;
        finfo_nxt = {hit, acc_in.fetch, acc_in.write};
      end
      else if (acc_in.addr < RPU_SYS_BASE)
      begin
        code_nxt = acc_in;
      end
      else
      begin
        sys_nxt = acc_in;
      end
    end
  end

  // Private bus register access
  always_comb
  begin
    int idx;
    idx           = 0;
    unit_en_nxt   = unit_en_r;
    ppb_rdata_nxt = 32'h0000_0000;
    for (int i = 0; i < NREG; i++)
    begin
      rgn_nxt[i] = rgn_r[i];
    end
    if (ppb_in.sel)
    begin
      if (ppb_in.addr == RPU_OFF_CTRL)
      begin
        ppb_rdata_nxt = {31'h0, unit_en_r};
        if (ppb_in.wr)
        begin
          unit_en_nxt = ppb_in.wdata[0];
        end
      end
      else if (ppb_in.addr == RPU_OFF_FADDR)
      begin
        ppb_rdata_nxt = faddr_r;
      end
      else if (ppb_in.addr == RPU_OFF_FINFO)
      begin
        ppb_rdata_nxt = {29'h0, finfo_r};
      end
      else if (ppb_in.addr >= RPU_OFF_RGN0 &&
               int'(ppb_in.addr) < int'(RPU_OFF_RGN0) + NREG * RPU_RGN_STRIDE)
      begin
        idx = (int'(ppb_in.addr) - int'(RPU_OFF_RGN0)) / RPU_RGN_STRIDE;
        if (ppb_in.addr[2])
        begin
          ppb_rdata_nxt = {14'h0, rgn_r[idx].perm, rgn_r[idx].srd, 2'h0,
                           rgn_r[idx].size, rgn_r[idx].en};
          if (ppb_in.wr)
          begin
            rgn_nxt[idx].en   = ppb_in.wdata[RPU_ATTR_EN];
            rgn_nxt[idx].size = ppb_in.wdata[RPU_ATTR_SIZE +: 5];
            rgn_nxt[idx].srd  = ppb_in.wdata[RPU_ATTR_SRD +: 8];
            rgn_nxt[idx].perm = rpu_perm_t'(ppb_in.wdata[RPU_ATTR_PERM +: 2]);
          end
        end
        else
        begin
          ppb_rdata_nxt = {rgn_r[idx].base, 5'h00};
          if (ppb_in.wr)
          begin
            rgn_nxt[idx].base = ppb_in.wdata[31:5];
          end
        end
      end
    end
  end

  // Access path registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      code_r  <= '0;
      sys_r   <= '0;
      fault_r <= 1'b0;
      faddr_r <= RPU_RST_WORD;
      finfo_r <= 3'h0;
    end
    else
    begin
      code_r  <= code_nxt;
      sys_r   <= sys_nxt;
      fault_r <= fault_nxt;
      faddr_r <= faddr_nxt;
      finfo_r <= finfo_nxt;
    end
  end

  // Settings registers; a write applies from the next access on
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      unit_en_r   <= 1'b0;
      ppb_rdata_r <= RPU_RST_WORD;
      for (int i = 0; i < NREG; i++)
      begin
        rgn_r[i] <= '0;
      end
    end
    else
    begin
      unit_en_r   <= unit_en_nxt;
      ppb_rdata_r <= ppb_rdata_nxt;
      for (int i = 0; i < NREG; i++)
      begin
        rgn_r[i] <= rgn_nxt[i];
      end
    end
  end

  assign ppb_rdata     = ppb_rdata_r;
  assign code_out      = code_r;
  assign sys_out       = sys_r;
  assign mm_fault      = fault_r;
  assign mm_fault_addr = faddr_r;

endmodule

// >>> verification/rpu_core_model.sv
`timescale 1ns/1ps
module rpu_core_model
  import rpu_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Requests
  output rpu_acc_t  acc_out,
  output rpu_ppb_t  ppb_out
);
  initial
  begin
    acc_out = '0;
    ppb_out = '0;
  end
  // Released lines show stale values, inverted except the access write and fetch lines
  task automatic acc(input logic w, f, input logic [31:0] a);
    @(posedge clk) #1 acc_out = '{1'b1, w, f, a};
    @(posedge clk) #1 acc_out = '{1'b0, w, f, ~a};
  endtask
  task automatic ppb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) #1 ppb_out = '{1'b1, w, a, d};
    @(posedge clk) #1 ppb_out = '{1'b0, ~w, ~a, ~d};
  endtask
endmodule

// >>> verification/rpu_top_sva.sv
`timescale 1ns/1ps
module rpu_top_sva
  import rpu_pkg::*;
(
  // Clock, reset, inputs
  input wire logic        clk,
  input wire logic        reset,
  input wire rpu_acc_t    acc_in,
  input wire rpu_ppb_t    ppb_in,
  // Outputs
  input wire logic [31:0] ppb_rdata,
  input wire rpu_acc_t    code_out,
  input wire rpu_acc_t    sys_out,
  input wire logic        mm_fault,
  input wire logic [31:0] mm_fault_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  code_route_a: assert property (code_out.valid |-> code_out == $past(acc_in) && code_out.addr < RPU_SYS_BASE)
    else $error("code port misrouted");
  sys_route_a: assert property (sys_out.valid |-> sys_out == $past(acc_in) && sys_out.addr >= RPU_SYS_BASE)
    else $error("system port misrouted");
  one_answer_a: assert property (acc_in.valid |=> $onehot({code_out.valid, sys_out.valid, mm_fault}))
    else $error("access not answered once");
  idle_quiet_a: assert property (!acc_in.valid |=> !(code_out.valid || sys_out.valid || mm_fault))
    else $error("answer without access");
  fault_addr_a: assert property (mm_fault |-> mm_fault_addr == $past(acc_in.addr))
    else $error("fault address wrong");
  fault_hold_a: assert property (!mm_fault |-> $stable(mm_fault_addr))
    else $error("fault address moved");
  rdata_idle_a: assert property (!$past(ppb_in.sel) |-> ppb_rdata == 32'h0)
    else $error("read data without access");
  rst_quiet_a: assert property ($past(reset) |-> !(mm_fault || code_out.valid || sys_out.valid))
    else $error("output active after reset");
endmodule
bind rpu_top rpu_top_sva rpu_top_sva_inst (.clk(clk), .reset(reset), .acc_in(acc_in), .ppb_in(ppb_in),
  .ppb_rdata(ppb_rdata), .code_out(code_out), .sys_out(sys_out), .mm_fault(mm_fault),
  .mm_fault_addr(mm_fault_addr));

// >>> verification/rpu_top_tb.sv
`timescale 1ns/1ps
module rpu_top_tb
  import rpu_pkg::*;
;
  logic        clk;
  logic        reset;
  rpu_acc_t    acc_in;
  rpu_ppb_t    ppb_in;
  logic [31:0] ppb_rdata;
  rpu_acc_t    code_out;
  rpu_acc_t    sys_out;
  logic        mm_fault;
  logic [31:0] mm_fault_addr;
  int          num_errors;
  int          num_checks;
  rpu_top rpu_top_inst (.clk(clk), .reset(reset), .acc_in(acc_in), .ppb_in(ppb_in), .ppb_rdata(ppb_rdata),
    .code_out(code_out), .sys_out(sys_out), .mm_fault(mm_fault), .mm_fault_addr(mm_fault_addr));
  rpu_core_model rpu_core_model_inst (.clk(clk), .acc_out(acc_in), .ppb_out(ppb_in));
  always #50 clk = ~clk;
  task automatic check(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    rpu_core_model_inst.ppb(1'b1, a, d);
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    rpu_core_model_inst.ppb(1'b0, a, 32'h0);
    d = ppb_rdata;
  endtask
  // Want 4 = code port, 2 = system port, 1 = fault
  task automatic go(input logic w, f, input logic [31:0] a, input logic [2:0] want);
    rpu_core_model_inst.acc(w, f, a);
    check({29'h0, code_out.valid, sys_out.valid, mm_fault}, {29'h0, want});
    check(want[2] ? code_out.addr : want[1] ? sys_out.addr : mm_fault_addr, a);
  endtask
  task automatic t_route;
    go(1'b0, 1'b1, 32'h1fff_fffc, 3'h4);
    go(1'b1, 1'b0, 32'h2000_0000, 3'h2);
  endtask
  task automatic t_nomatch;
    put(RPU_OFF_CTRL, 32'h0000_0001);
    go(1'b0, 1'b0, 32'h4000_0000, 3'h1);
  endtask
  task automatic t_ro;
    put(8'h14, 32'h0001_0013);
    rpu_core_model_inst.ppb(1'b0, 8'h14, 32'h0);
    check(ppb_rdata, 32'h0001_0013);
    go(1'b0, 1'b0, 32'h0000_0040, 3'h4);
    go(1'b0, 1'b1, 32'h0000_0044, 3'h4);
    go(1'b1, 1'b0, 32'h0000_0040, 3'h1);
  endtask
  task automatic t_deny;
    put(8'h1c, 32'h0000_000f);
    go(1'b0, 1'b1, 32'h0000_0020, 3'h1);
    go(1'b0, 1'b0, 32'h0000_0200, 3'h4);
    put(8'h1c, 32'h0000_040f);
    go(1'b0, 1'b0, 32'h0000_0040, 3'h4);
    go(1'b1, 1'b0, 32'h0000_0020, 3'h1);
  endtask
  task automatic t_top;
    put(8'h48, 32'h2000_0000);
    put(8'h4c, 32'h0002_0013);
    go(1'b1, 1'b0, 32'h2000_0010, 3'h2);
    go(1'b1, 1'b0, 32'h2000_0400, 3'h1);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    get(RPU_OFF_CTRL, d);
    check(d, 32'h0000_0001);
    get(RPU_OFF_FADDR, d);
    check(d, 32'h2000_0400);
    get(RPU_OFF_FINFO, d);
    check(d, 32'h0000_0001);
    put(RPU_OFF_FADDR, 32'h0000_0000);
    get(RPU_OFF_FADDR, d);
    check(d, 32'h2000_0400);
    put(8'h4c, 32'h0003_0013);
    go(1'b0, 1'b1, 32'h2000_0010, 3'h1);
    get(RPU_OFF_FINFO, d);
    check(d, 32'h0000_0006);
    get(8'h48, d);
    check(d, 32'h2000_0000);
    put(8'h44, 32'h0002_0007);
    go(1'b0, 1'b0, 32'h0000_0008, 3'h1);
    put(8'h0c, 32'hffff_ffff);
    get(8'h0c, d);
    check(d, 32'h0000_0000);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    @(posedge clk) #1 reset = 1'b1;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    get(RPU_OFF_CTRL, d);
    check(d, 32'h0000_0000);
    get(8'h4c, d);
    check(d, 32'h0000_0000);
    go(1'b0, 1'b0, 32'h4000_0000, 3'h2);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    num_errors = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    t_route;
    t_nomatch;
    t_ro;
    t_deny;
    t_top;
    t_regs;
    t_reset;
    finish_test;
  end
  // About 77 cycles of tests
  initial
  begin
    #100000;
    num_errors++;
    finish_test;
  end
endmodule
